// ===== logic/csn_fifo.sv
// 16-bit word FIFO with registered read data and synchronous clear.
// Ignores push while full and pop while empty.
`timescale 1ns/10ps
module csn_fifo (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  // Write side
  input wire logic push,
  input wire logic [15:0] wrData,
  // Read side
  input wire logic pop,
  output logic [15:0] rdData,
  // State
  output logic [8:0] count,
  output logic empty,
  output logic full
);
  logic [15:0] mem [csn_pkg::FIFO_DEPTH];
  logic [7:0] wrPtr_reg;
  logic [7:0] rdPtr_reg;
  logic [8:0] count_reg;
  logic [15:0] rdData_reg;
  wire doPush = push && !full;
  wire doPop = pop && !empty;

  assign count = count_reg;
  assign empty = (count_reg == 9'h000);
  assign full = (count_reg == 9'(csn_pkg::FIFO_DEPTH));
  assign rdData = rdData_reg;

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= wrData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= 8'h00;
      rdPtr_reg <= 8'h00;
      count_reg <= 9'h000;
      rdData_reg <= 16'h0000;
    end else if (clear) begin
      wrPtr_reg <= 8'h00;
      rdPtr_reg <= 8'h00;
      count_reg <= 9'h000;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 8'h01;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 8'h01;
        rdData_reg <= mem[rdPtr_reg];
      end
      count_reg <= count_reg + 9'(doPush) - 9'(doPop);
    end
  end
endmodule

// ===== logic/csn_master_ctrl.sv
// Control logic of a master on a half-duplex coaxial serial network.
// Assumes a classic Wishbone master and a byte-wide network node outside.
//
// Contract
// - Start function with data buffered puts node in transmit and sends packet.
// - Start with empty transmit buffer sends nothing and stores FFFD.
// - Start answers Q=1 when accepted, Q=0 while node is busy.
// - After sending wait about 500 ms; on silence store FFFF.
// - Bad response header clears receive buffer, then stores FFFE.
// - Response or error ready enables reads and raises LAM if enabled.
// - Read returns next word, Q=1 while data remain, else Q=0.
// - LAM drops once the last receive word is read.
// - Function 26 enables LAM; 24, 9, C, Z and button disable.
// - LAM generation is disabled after power-up.
// - LAM test answers Q=1 when LAM asserted, else Q=0.
// - Reset, C and Z clear buffers, clear LAM, abort transfers.
// - Write stores word with Q=1; Q=0 when busy or full.
// - X answers every implemented function.
// - Q answers every implemented function unless a condition governs it.
// - Both buffers are 16-bit first-in first-out queues.
// - Received slave packet enters receive buffer automatically.
// - Any reset holds restart mode about 3 ms, refusing commands.
// - Dataway words pass through byte-wide node paths.
// - Node clock runs at three times the 1 MBaud line rate; the divider here gives 3.125 MHz.
`timescale 1ns/10ps
module csn_master_ctrl #(
  parameter logic [25:0] RESP_TIMEOUT_CYCLES = 26'(csn_pkg::RESP_TIMEOUT_CYC),
  parameter logic [25:0] RESTART_CYCLES = 26'(csn_pkg::RESTART_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Dataway lines
  input wire logic dwClear,
  input wire logic dwInit,
  input wire logic panelReset,
  output logic lam,
  // Network node
  output logic nodeClk,
  output logic nodeRestart,
  output logic nodeTxMode,
  output logic [7:0] nodeTxData,
  output logic nodeTxLast,
  output logic nodeTxValid,
  input wire logic nodeTxReady,
  input wire logic nodeTxDone,
  input wire logic [7:0] nodeRxData,
  input wire logic nodeRxValid,
  input wire logic nodeRxEnd
);
  csn_pkg::csn_state_t state_reg, state_next;
  logic restart_reg, lamEn_reg, lamReq_reg, readEn_reg;
  logic lastQ_reg, lastX_reg, pend_reg, ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] errWord_reg, firstWord_reg;
  logic [7:0] rxLo_reg;
  logic rxHalf_reg, gotFirst_reg;
  logic [5:0] div_reg;
  logic nodeClk_reg;

  // Bus request decode
  wire start = wb_cyc_i && wb_stb_i && !pend_reg && !ack_reg;
  wire selLo = wb_sel_i[0] && wb_sel_i[1];
  wire hitData = (wb_adr_i == csn_pkg::ADDR_DATA);
  wire hitFunc = (wb_adr_i == csn_pkg::ADDR_FUNC);
  wire [4:0] fn = hitData ? (wb_we_i ? csn_pkg::FN_WRITE : csn_pkg::FN_READ) : wb_dat_i[4:0];
  wire isFn = start && !restart_reg && (hitData || (hitFunc && wb_we_i && selLo));
  wire busy = (state_reg != csn_pkg::ST_IDLE);

  // Buffers
  logic [15:0] txRd, rxRd, rxWr;
  logic [8:0] rxCount;
  logic txEmpty, txFull, rxEmpty, rxFull, txPop, rxPush, rxPop;
  logic rxClear, respDone, restartDone;

  wire fnRead = isFn && fn == csn_pkg::FN_READ;
  wire fnWrite = isFn && fn == csn_pkg::FN_WRITE && selLo;
  wire fnStart = isFn && fn == csn_pkg::FN_START;
  wire fnReset = isFn && fn == csn_pkg::FN_RESET;
  wire fnLamOn = isFn && fn == csn_pkg::FN_LAM_ON;
  wire fnLamOff = isFn && fn == csn_pkg::FN_LAM_OFF;
  wire fnTest = isFn && fn == csn_pkg::FN_TEST_LAM;
  wire known = fnRead || fnWrite || fnStart || fnReset || fnLamOn || fnLamOff || fnTest;

  wire readQ = readEn_reg && !rxEmpty;
  wire writeQ = !busy && !txFull;
  wire startQ = !busy;
  wire fnQ = fnRead ? readQ : fnWrite ? writeQ : fnStart ? startQ
           : fnTest ? lam : known;
  wire lastRead = fnRead && readQ && rxCount == 9'h001;
  wire anyReset = fnReset || dwClear || dwInit || panelReset;

  assign rxPop = fnRead && readQ;
  assign lam = lamReq_reg && lamEn_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign nodeClk = nodeClk_reg;
  assign nodeRestart = restart_reg;

  csn_fifo txBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(restart_reg),
    .push(fnWrite && writeQ),
    .wrData(wb_dat_i[15:0]),
    .pop(txPop),
    .rdData(txRd),
    .count(),
    .empty(txEmpty),
    .full(txFull)
  );

  csn_fifo rxBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(rxClear),
    .push(rxPush),
    .wrData(rxWr),
    .pop(rxPop),
    .rdData(rxRd),
    .count(rxCount),
    .empty(rxEmpty),
    .full(rxFull)
  );

  csn_timer respTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(state_reg != csn_pkg::ST_RESP_WAIT),
    .run(1'b1),
    .limit(RESP_TIMEOUT_CYCLES),
    .done(respDone)
  );

  csn_timer restartTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(!restart_reg || anyReset),
    .run(1'b1),
    .limit(RESTART_CYCLES),
    .done(restartDone)
  );

  // Received word assembly, low byte first
  wire rxActive = state_reg == csn_pkg::ST_RESP_WAIT || state_reg == csn_pkg::ST_RX;
  wire rxWordIn = rxActive && nodeRxValid && rxHalf_reg;
  wire [15:0] rxWord = {nodeRxData, rxLo_reg};
  wire hdrOk = firstWord_reg == csn_pkg::HDR_OK || firstWord_reg[15:8] == csn_pkg::HDR_ERR_HI;
  wire pushErr = state_reg == csn_pkg::ST_PUSH_ERR;

  assign rxPush = pushErr || (rxWordIn && !rxFull) || (fnStart && startQ && txEmpty);
  assign rxWr = pushErr ? errWord_reg : (rxWordIn ? rxWord : csn_pkg::ERR_TX_EMPTY);
  assign rxClear = restart_reg || state_reg == csn_pkg::ST_CLEAR;
  assign txPop = state_reg == csn_pkg::ST_TX_FETCH;
  assign nodeTxMode = state_reg == csn_pkg::ST_TX_FETCH || state_reg == csn_pkg::ST_TX_LO
                   || state_reg == csn_pkg::ST_TX_HI || state_reg == csn_pkg::ST_TX_WAIT;
  assign nodeTxValid = state_reg == csn_pkg::ST_TX_LO || state_reg == csn_pkg::ST_TX_HI;
  assign nodeTxData = (state_reg == csn_pkg::ST_TX_HI) ? txRd[15:8] : txRd[7:0];
  assign nodeTxLast = state_reg == csn_pkg::ST_TX_HI && txEmpty;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      csn_pkg::ST_IDLE: begin
        if (fnStart && !txEmpty) begin
          state_next = csn_pkg::ST_TX_FETCH;
        end
      end
      csn_pkg::ST_TX_FETCH: begin
        state_next = csn_pkg::ST_TX_LO;
      end
      csn_pkg::ST_TX_LO: begin
        if (nodeTxReady) begin
          state_next = csn_pkg::ST_TX_HI;
        end
      end
      csn_pkg::ST_TX_HI: begin
        if (nodeTxReady) begin
          state_next = txEmpty ? csn_pkg::ST_TX_WAIT : csn_pkg::ST_TX_FETCH;
        end
      end
      csn_pkg::ST_TX_WAIT: begin
        if (nodeTxDone) begin
          state_next = csn_pkg::ST_RESP_WAIT;
        end
      end
      csn_pkg::ST_RESP_WAIT: begin
        if (nodeRxValid) begin
          state_next = csn_pkg::ST_RX;
        end else if (respDone) begin
          state_next = csn_pkg::ST_PUSH_ERR;
        end
      end
      csn_pkg::ST_RX: begin
        if (nodeRxEnd) begin
          state_next = hdrOk ? csn_pkg::ST_IDLE : csn_pkg::ST_CLEAR;
        end
      end
      csn_pkg::ST_CLEAR: begin
        state_next = csn_pkg::ST_PUSH_ERR;
      end
      default: begin
        state_next = csn_pkg::ST_IDLE;
      end
    endcase
  end

  wire respReady = (state_reg == csn_pkg::ST_RX && nodeRxEnd && hdrOk) || pushErr
                || (fnStart && startQ && txEmpty);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= csn_pkg::ST_IDLE;
      restart_reg <= 1'b1;
      lamEn_reg <= 1'b0;
      lamReq_reg <= 1'b0;
      readEn_reg <= 1'b0;
      errWord_reg <= 16'h0000;
    end else if (restart_reg || anyReset) begin
      state_reg <= csn_pkg::ST_IDLE;
      restart_reg <= !(restartDone && !anyReset);
      lamEn_reg <= 1'b0;
      lamReq_reg <= 1'b0;
      readEn_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == csn_pkg::ST_RESP_WAIT && state_next == csn_pkg::ST_PUSH_ERR) begin
        errWord_reg <= csn_pkg::ERR_TIMEOUT;
      end else if (state_next == csn_pkg::ST_CLEAR) begin
        errWord_reg <= csn_pkg::ERR_HEADER;
      end
      if (fnLamOn) begin
        lamEn_reg <= 1'b1;
      end else if (fnLamOff) begin
        lamEn_reg <= 1'b0;
      end
      // A completed response wins over a concurrent last read
      if (respReady) begin
        readEn_reg <= 1'b1;
        lamReq_reg <= 1'b1;
      end else if (lastRead) begin
        readEn_reg <= 1'b0;
        lamReq_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxHalf_reg <= 1'b0;
      rxLo_reg <= 8'h00;
      gotFirst_reg <= 1'b0;
      firstWord_reg <= 16'h0000;
    end else if (!rxActive) begin
      rxHalf_reg <= 1'b0;
      gotFirst_reg <= 1'b0;
    end else if (nodeRxValid) begin
      rxHalf_reg <= !rxHalf_reg;
      rxLo_reg <= nodeRxData;
      if (rxHalf_reg && !gotFirst_reg) begin
        firstWord_reg <= rxWord;
        gotFirst_reg <= 1'b1;
      end
    end
  end

  // Node clock divider; 125 MHz does not divide evenly, so the rate is near 3 MHz
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 6'h00;
      nodeClk_reg <= 1'b0;
    end else if (div_reg == 6'(csn_pkg::NODE_HALF_CYC - 1)) begin
      div_reg <= 6'h00;
      nodeClk_reg <= !nodeClk_reg;
    end else begin
      div_reg <= div_reg + 6'h01;
    end
  end

  // Bus answer: request taken, one cycle to fetch, then ack
  wire [31:0] statusWord = {25'h0000000, readEn_reg, restart_reg, busy, lamEn_reg, lam,
                            lastX_reg, lastQ_reg};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      lastQ_reg <= 1'b0;
      lastX_reg <= 1'b0;
    end else begin
      pend_reg <= start;
      ack_reg <= pend_reg;
      if (isFn) begin
        lastQ_reg <= fnQ;
        lastX_reg <= known;
      end else if (start && (hitData || hitFunc)) begin
        lastQ_reg <= 1'b0;
        lastX_reg <= 1'b0;
      end
      if (pend_reg) begin
        if (wb_adr_i == csn_pkg::ADDR_DATA && !wb_we_i) begin
          dat_reg <= {16'h0000, lastQ_reg ? rxRd : 16'h0000};
        end else if (wb_adr_i == csn_pkg::ADDR_STATUS && !wb_we_i) begin
          dat_reg <= statusWord;
        end else begin
          dat_reg <= 32'h00000000;
        end
      end
    end
  end
endmodule

// ===== logic/csn_pkg.sv
// Shared constants of the serial network master control block.
// Assumes a single 125 MHz core clock and a 32-bit classic Wishbone slave.
package csn_pkg;
  // Clock and timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned RESP_TIMEOUT_MS = 500;
  localparam int unsigned RESTART_US = 3000;
  localparam int unsigned RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned RESTART_CYC = (RESTART_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned TIMER_W = 26;
  // Node clock: three times the 1 MBaud line rate
  localparam int unsigned NODE_CLK_KHZ = 3000;
  localparam int unsigned NODE_HALF_CYC = CLK_KHZ / (2 * NODE_CLK_KHZ);
  localparam int unsigned NODE_DIV_W = 6;

  // Buffers
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 256;
  localparam int unsigned PTR_W = 8;
  localparam int unsigned CNT_W = 9;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_FUNC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Function codes
  localparam logic [4:0] FN_READ = 5'h00;
  localparam logic [4:0] FN_TEST_LAM = 5'h08;
  localparam logic [4:0] FN_RESET = 5'h09;
  localparam logic [4:0] FN_WRITE = 5'h10;
  localparam logic [4:0] FN_START = 5'h11;
  localparam logic [4:0] FN_LAM_OFF = 5'h18;
  localparam logic [4:0] FN_LAM_ON = 5'h1a;

  // Error words
  localparam logic [15:0] ERR_TX_EMPTY = 16'hfffd;
  localparam logic [15:0] ERR_HEADER = 16'hfffe;
  localparam logic [15:0] ERR_TIMEOUT = 16'hffff;
  localparam logic [15:0] HDR_OK = 16'h0000;
  localparam logic [7:0] HDR_ERR_HI = 8'hff;

  // Status bit positions
  localparam int unsigned ST_Q = 0;
  localparam int unsigned ST_X = 1;
  localparam int unsigned ST_LAM = 2;
  localparam int unsigned ST_LAM_EN = 3;
  localparam int unsigned ST_BUSY = 4;
  localparam int unsigned ST_RESTART = 5;
  localparam int unsigned ST_READ_EN = 6;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TX_FETCH, ST_TX_LO, ST_TX_HI, ST_TX_WAIT, ST_RESP_WAIT,
    ST_RX, ST_CLEAR, ST_PUSH_ERR
  } csn_state_t;
endpackage

// ===== logic/csn_timer.sv
// Cycle counter that flags when a programmable limit is reached.
// Assumes clear has priority over run.
`timescale 1ns/10ps
module csn_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [25:0] limit,
  // Result
  output logic done
);
  logic [25:0] cnt_reg;

  assign done = (cnt_reg >= limit);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 26'h0000000;
    end else if (clear) begin
      cnt_reg <= 26'h0000000;
    end else if (run && !done) begin
      cnt_reg <= cnt_reg + 26'h0000001;
    end
  end
endmodule

// ===== verification/camac_serial_net_master_ctrl_test.sv
// Self-checking bench acting as crate controller over Wishbone.
// Assumes the node model and short restart and timeout counts.
`timescale 1ns/10ps
module camac_serial_net_master_ctrl_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc, wbStb, wbWe, wbAck, dwClear, dwInit, panelReset, lam;
  logic nodeRestart, nodeTxMode, nodeTxLast, nodeTxValid, nodeTxReady, nodeTxDone;
  logic nodeRxValid, nodeRxEnd;
  logic [7:0] wbAdr, nodeTxData, nodeRxData;
  logic [31:0] wbDatI, wbDatO;
  logic [1:0] mode;
  logic [3:0] wbSel;
  logic nodeClk;
  logic [15:0] txw[$];
  int seed = 32'h70226916;
  int errTotal = 0;
  int nChecks = 0;
  int cycCnt = 0;
  always #4 core_clk = ~core_clk;
  csn_master_ctrl #(.RESP_TIMEOUT_CYCLES(26'd200), .RESTART_CYCLES(26'd20)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .dwClear(dwClear), .dwInit(dwInit),
    .panelReset(panelReset), .lam(lam), .nodeClk(nodeClk), .nodeRestart(nodeRestart),
    .nodeTxMode(nodeTxMode), .nodeTxData(nodeTxData), .nodeTxLast(nodeTxLast),
    .nodeTxValid(nodeTxValid), .nodeTxReady(nodeTxReady), .nodeTxDone(nodeTxDone),
    .nodeRxData(nodeRxData), .nodeRxValid(nodeRxValid), .nodeRxEnd(nodeRxEnd));
  csn_node_model node (
    .core_clk(core_clk), .mode(mode), .nodeRestart(nodeRestart),
    .nodeTxData(nodeTxData), .nodeTxLast(nodeTxLast), .nodeTxValid(nodeTxValid),
    .nodeTxReady(nodeTxReady), .nodeTxDone(nodeTxDone), .nodeRxData(nodeRxData),
    .nodeRxValid(nodeRxValid), .nodeRxEnd(nodeRxEnd));
  task automatic testDone();
    $display("Checks %0d, errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycCnt++;
    if (cycCnt > 20000) begin
      errTotal++;
      testDone();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] r);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbSel <= 4'hf;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {16'h0, d};
    // Only the bench timeout ends a wait for ack
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'b1);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic fn(input logic [4:0] c, output logic [31:0] s);
    wb(1'b1, csn_pkg::ADDR_FUNC, {11'h0, c}, s);
    wb(1'b0, csn_pkg::ADDR_STATUS, 16'h0, s);
  endtask
  task automatic xfer(input logic we, inout logic [15:0] d, output logic q);
    logic [31:0] r;
    wb(we, csn_pkg::ADDR_DATA, d, r);
    if (!we) d = r[15:0];
    wb(1'b0, csn_pkg::ADDR_STATUS, 16'h0, r);
    q = r[csn_pkg::ST_Q];
  endtask
  task automatic pollSt(input int b, input logic v, output logic [31:0] s);
    int n;
    n = 0;
    do begin
      wb(1'b0, csn_pkg::ADDR_STATUS, 16'h0, s);
      n++;
    end while (s[b] !== v && n < 200);
    chk("status poll", 16'(v), 16'(s[b]));
  endtask
  function automatic logic [15:0] expWord(input int m, input int i);
    if (m == 1) return csn_pkg::ERR_HEADER;
    if (m == 2) return csn_pkg::ERR_TIMEOUT;
    return (i == 0) ? csn_pkg::HDR_OK : txw[i - 1];
  endfunction
  initial begin
    logic [31:0] s;
    logic [15:0] d;
    logic q;
    int n;
    {wbCyc, wbStb, wbWe, dwClear, dwInit, panelReset} = 6'h0;
    wbAdr = 8'h0;
    wbDatI = 32'h0;
    wbSel = 4'h0;
    mode = 2'd0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    fn(csn_pkg::FN_LAM_ON, s);
    chk("restart X", 16'h0, 16'(s[csn_pkg::ST_X]));
    pollSt(csn_pkg::ST_RESTART, 1'b0, s);
    chk("lamEn at start", 16'h0, 16'(s[csn_pkg::ST_LAM_EN]));
    wb(1'b0, 8'h0c, 16'h0, s);
    chk("unmapped", 16'h0, s[15:0]);
    @(posedge nodeClk);
    n = cycCnt;
    @(posedge nodeClk);
    chk("node clock period", 16'(2 * csn_pkg::NODE_HALF_CYC), 16'(cycCnt - n));
    fn(csn_pkg::FN_START, s);
    chk("empty start Q", 16'h1, 16'(s[csn_pkg::ST_Q]));
    xfer(1'b0, d, q);
    chk("empty word", csn_pkg::ERR_TX_EMPTY, d);
    xfer(1'b0, d, q);
    chk("drained Q", 16'h0, 16'(q));
    for (int m = 0; m < 3; m++) begin
      mode <= 2'(m);
      fn(m == 2 ? csn_pkg::FN_LAM_OFF : csn_pkg::FN_LAM_ON, s);
      chk("lamEn", 16'(m != 2), 16'(s[csn_pkg::ST_LAM_EN]));
      txw.delete();
      n = 1 + ($random(seed) & 3);
      repeat (n) begin
        d = 16'($random(seed));
        txw.push_back(d);
        xfer(1'b1, d, q);
        chk("write Q", 16'h1, 16'(q));
      end
      fn(csn_pkg::FN_START, s);
      chk("start Q", 16'h1, 16'(s[csn_pkg::ST_Q]));
      d = 16'h55aa;
      xfer(1'b1, d, q);
      chk("busy write Q", 16'h0, 16'(q));
      fn(csn_pkg::FN_START, s);
      chk("busy start Q", 16'h0, 16'(s[csn_pkg::ST_Q]));
      if (m != 2) begin
        while (lam !== 1'b1) @(posedge core_clk);
      end
      pollSt(csn_pkg::ST_READ_EN, 1'b1, s);
      chk("lam up", 16'(m != 2), 16'(lam));
      fn(csn_pkg::FN_TEST_LAM, s);
      chk("lam test Q", 16'(m != 2), 16'(s[csn_pkg::ST_Q]));
      for (int i = 0; i < (m == 0 ? txw.size() + 1 : 1); i++) begin
        xfer(1'b0, d, q);
        chk("resp word", expWord(m, i), d);
        chk("resp Q", 16'h1, 16'(q));
      end
      chk("lam after last", 16'h0, 16'(lam));
      xfer(1'b0, d, q);
      chk("end Q", 16'h0, 16'(q));
    end
    // Leave a pending error word and LAM up, so the resets have work to undo
    fn(csn_pkg::FN_LAM_ON, s);
    fn(csn_pkg::FN_START, s);
    for (int i = 0; i < 257; i++) begin
      d = 16'(i);
      xfer(1'b1, d, q);
      chk("fill Q", 16'(i < 256), 16'(q));
    end
    for (int r = 0; r < 4; r++) begin
      if (r == 0) fn(csn_pkg::FN_RESET, s);
      else begin
        dwClear <= (r == 1);
        dwInit <= (r == 2);
        panelReset <= (r == 3);
        repeat (2) @(posedge core_clk);
        {dwClear, dwInit, panelReset} <= 3'h0;
      end
      chk("lam cleared", 16'h0, 16'(lam));
      fn(csn_pkg::FN_LAM_ON, s);
      chk("restart refuses", 16'h0, 16'(s[csn_pkg::ST_X]));
      pollSt(csn_pkg::ST_RESTART, 1'b0, s);
      chk("lamEn cleared", 16'h0, 16'(s[csn_pkg::ST_LAM_EN]));
      xfer(1'b0, d, q);
      chk("rx cleared Q", 16'h0, 16'(q));
      fn(csn_pkg::FN_LAM_ON, s);
      fn(csn_pkg::FN_START, s);
      pollSt(csn_pkg::ST_READ_EN, 1'b1, s);
      chk("error lam", 16'h1, 16'(lam));
    end
    xfer(1'b0, d, q);
    chk("tx cleared", csn_pkg::ERR_TX_EMPTY, d);
    testDone();
  end
endmodule

// ===== verification/csn_master_ctrl_checker.sv
// Port assertions for the serial network master control block.
// Assumes one clock domain and the short parameter values of the bench.
`timescale 1ns/10ps
module csn_master_ctrl_checker #(
  parameter logic [25:0] RESP_TIMEOUT_CYCLES = 26'd200,
  parameter logic [25:0] RESTART_CYCLES = 26'd20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Dataway
  input wire logic dwClear,
  input wire logic dwInit,
  input wire logic panelReset,
  input wire logic lam,
  // Node
  input wire logic nodeRestart,
  input wire logic nodeTxMode,
  input wire logic [7:0] nodeTxData,
  input wire logic nodeTxValid,
  input wire logic nodeTxReady
);
  wire logic fnWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == csn_pkg::ADDR_FUNC;
  wire logic startReq = fnWr && wb_dat_i[4:0] == csn_pkg::FN_START;
  wire logic lamOffReq = fnWr && wb_dat_i[4:0] == csn_pkg::FN_LAM_OFF;
  wire logic rstReq = dwClear || dwInit || panelReset;
  logic [25:0] rstCnt_reg;
  // Counts restart length; too long for a repetition operator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rstCnt_reg <= 26'h0;
    else rstCnt_reg <= nodeRestart ? rstCnt_reg + 26'h1 : 26'h0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence sNewReq;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence sAckTwo;
    ##1 !wb_ack_o ##1 wb_ack_o;
  endsequence
  sequence sStall;
    nodeTxValid && !nodeTxReady ##1 !nodeRestart;
  endsequence
  AST_ACK_TIMING: assert property (sNewReq |-> sAckTwo)
    else $error("ack not two cycles after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_TX_HOLD: assert property (sStall |-> nodeTxValid && $stable(nodeTxData))
    else $error("tx byte dropped before ready");
  AST_VALID_IN_TX: assert property (nodeTxValid |-> nodeTxMode)
    else $error("byte offered outside transmit mode");
  AST_TX_FROM_START: assert property ($rose(nodeTxMode) |->
    $past(startReq) || $past(startReq, 2))
    else $error("transmit mode without start");
  AST_RESTART_QUIET: assert property (nodeRestart |-> !nodeTxMode && !lam)
    else $error("activity during restart");
  AST_RESET_SRC: assert property (rstReq |-> ##[1:3] nodeRestart)
    else $error("reset source ignored");
  AST_LAM_OFF: assert property (lamOffReq && wb_ack_o |-> !lam)
    else $error("lam after disable");
  AST_RESTART_LEN: assert property ($fell(nodeRestart) |->
    rstCnt_reg + 26'd2 >= RESTART_CYCLES && rstCnt_reg <= RESTART_CYCLES + 26'd6)
    else $error("restart length wrong");
endmodule
bind csn_master_ctrl csn_master_ctrl_checker #(
  .RESP_TIMEOUT_CYCLES(RESP_TIMEOUT_CYCLES), .RESTART_CYCLES(RESTART_CYCLES)
) chkr (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .dwClear(dwClear), .dwInit(dwInit), .panelReset(panelReset), .lam(lam),
  .nodeRestart(nodeRestart), .nodeTxMode(nodeTxMode), .nodeTxData(nodeTxData),
  .nodeTxValid(nodeTxValid), .nodeTxReady(nodeTxReady)
);

// ===== verification/csn_node_model.sv
// Behavioural network node with one addressed slave behind it.
// Assumes one packet in flight; mode 0 echoes, 1 bad header, 2 silent.
`timescale 1ns/10ps
module csn_node_model (
  // Clock and control
  input wire logic core_clk,
  input wire logic [1:0] mode,
  input wire logic nodeRestart,
  // Transmit bytes
  input wire logic [7:0] nodeTxData,
  input wire logic nodeTxLast,
  input wire logic nodeTxValid,
  output logic nodeTxReady,
  output logic nodeTxDone,
  // Receive bytes
  output logic [7:0] nodeRxData,
  output logic nodeRxValid,
  output logic nodeRxEnd
);
  logic [7:0] pkt[$];
  event pktOut;
  // Ready only every other cycle, so the sender must hold its byte
  always @(posedge core_clk) begin
    nodeTxReady <= nodeRestart ? 1'b0 : ~nodeTxReady;
    if (nodeRestart) pkt.delete();
    else if (nodeTxValid && nodeTxReady) begin
      pkt.push_back(nodeTxData);
      if (nodeTxLast) -> pktOut;
    end
  end
  task automatic sendByte(input logic [7:0] b);
    nodeRxData <= b;
    nodeRxValid <= 1'b1;
    @(posedge core_clk);
    nodeRxValid <= 1'b0;
    nodeRxData <= ~b;
    repeat (2) @(posedge core_clk);
  endtask
  // Slave answers after each packet except in mode 2, low byte first
  initial begin
    nodeTxDone = 1'b0;
    nodeRxData = 8'h3c;
    nodeRxValid = 1'b0;
    nodeRxEnd = 1'b0;
    forever begin
      @(pktOut);
      repeat (4) @(posedge core_clk);
      nodeTxDone <= 1'b1;
      @(posedge core_clk);
      nodeTxDone <= 1'b0;
      if (mode != 2'd2) begin
        repeat (8) @(posedge core_clk);
        sendByte(8'h00);
        sendByte(mode == 2'd1 ? 8'h34 : 8'h00);
        foreach (pkt[i]) sendByte(pkt[i]);
        nodeRxEnd <= 1'b1;
        @(posedge core_clk);
        nodeRxEnd <= 1'b0;
      end
      pkt.delete();
    end
  end
endmodule
